// [rieps_pkg.sv]
package rieps_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [9:0] REG_INPUT_MODE_CONTROL = 10'h300;
    localparam logic [9:0] REG_INPUT_EXPONENT_CONTROL = 10'h305;
    localparam logic [9:0] REG_INPUT_STATUS = 10'h306;
    localparam logic [9:0] REG_SAMPLE_COUNT = 10'h307;
    localparam int ADDR_W = 12;
    // Field positions
    localparam int MODE_LSB = 0;
    localparam int EXP_OFFSET_LSB = 5;
    localparam int EXP_INVERT_BIT = 4;
    // Reset values
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] EXP_CTRL_RESET = 8'h00;
    // Input mode encodings
    localparam logic [1:0] MODE_SINGLE_REAL = 2'h0;
    localparam logic [1:0] MODE_DIVERSITY_REAL = 2'h1;
    localparam logic [1:0] MODE_SINGLE_COMPLEX = 2'h2;
    // Widths
    localparam int MANTISSA_W = 16;
    localparam int EXPONENT_W = 3;
    localparam int FIFO_DEPTH = 16;
    // Fastest sample rate in MSPS, and clock rate in MHz
    localparam int MAX_SAMPLE_MSPS = 65;
    localparam int CLOCK_MHZ = 250;
    // Bus slave state machine
    typedef enum logic [2:0] {
        RIEPS_BUS_IDLE = 3'b001,
        RIEPS_BUS_DONE = 3'b010,
        RIEPS_BUS_HOLD = 3'b100
    } rieps_bus_state_t;
endpackage

// [rieps_fifo.sv]
`timescale 1ns/100ps
module rieps_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Filling side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Draining side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("rieps_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire logic [AW:0] used = wr_ptr - rd_ptr;
    wire logic full = used == (AW+1)'(DEPTH);
    wire logic empty = used == '0;
    wire logic push = in_valid_in && !full;
    wire logic pop = !empty && out_ready_in;

    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[rd_ptr[AW-1:0]];

    // Storage has no reset; only the pointers matter for validity
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    // Pointers carry an extra bit so full and empty stay distinct
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge clk_in) disable iff (reset_in)
        full |=> used == (AW+1)'(DEPTH) || $past(pop))
        else $error("FIFO count moved while full without a pop");
endmodule

// [rieps_input_port.sv]
`timescale 1ns/100ps
// Summary of operation
// - Capture mantissa, exponent, select on rising edge
// - Mantissa is 16-bit two's complement
// - Exponent is 3-bit unsigned
// - Offset field in bits 7:5 of 0x305
// - Invert bit is bit 4 of 0x305
// - Invert low: shift by exponent plus offset
// - Invert high: shift by seven minus exponent plus offset
// - Three input modes chosen at 0x300
// - Complex mode: select marks in-phase or quadrature
// - Following stage takes full scale without wrap
// - Single real: select is active-high sample enable
// - Diversity: select high channel A, low B
// - Diversity: only first sample after select change
module rieps_input_port #(
    parameter int MANTISSA_W = rieps_pkg::MANTISSA_W,
    parameter int FIFO_DEPTH = rieps_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Converter pins
    input wire logic [MANTISSA_W-1:0] mantissa_in,
    input wire logic [rieps_pkg::EXPONENT_W-1:0] exponent_in,
    input wire logic channel_select_in,
    // Avalon-MM slave
    input wire logic [rieps_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    // Scaled sample stream
    output logic sample_valid_out,
    output logic [MANTISSA_W-1:0] sample_data_out,
    output logic sample_channel_a_out,
    output logic sample_in_phase_out,
    input wire logic sample_ready_in
);
    localparam int SHIFT_W = rieps_pkg::EXPONENT_W;
    localparam int FIFO_W = MANTISSA_W + 2;

    initial begin
        if (MANTISSA_W != rieps_pkg::MANTISSA_W || FIFO_DEPTH < 2) begin
            $error("rieps_input_port: unsupported parameter values");
        end
        if (rieps_pkg::CLOCK_MHZ < rieps_pkg::MAX_SAMPLE_MSPS) begin
            $error("rieps_input_port: clock too slow for the full sample rate");
        end
    end

    // Decode a byte address into a register index; misaligned gives no hit
    function automatic logic [9:0] reg_index(input logic [rieps_pkg::ADDR_W-1:0] addr);
        reg_index = (addr[1:0] == 2'h0) ? addr[11:2] : 10'h3FF;
    endfunction

    // Control registers
    logic [1:0] input_mode;
    logic [7:0] input_exponent_control;
    logic [31:0] sample_count;
    logic overflow_flag;

    // Captured pins, one register stage; the next edge uses them
    logic [MANTISSA_W-1:0] cap_mantissa;
    logic [SHIFT_W-1:0] cap_exponent;
    logic cap_select;
    logic prev_select;
    logic prev_select_valid;

    // Pin capture on every rising edge
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cap_mantissa <= 16'h0000;
            cap_exponent <= 3'h0;
            cap_select <= 1'b0;
        end else begin
            cap_mantissa <= mantissa_in;
            cap_exponent <= exponent_in;
            cap_select <= channel_select_in;
        end
    end

    // Select history for change detection in diversity mode
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            prev_select <= 1'b0;
            prev_select_valid <= 1'b0;
        end else begin
            prev_select <= cap_select;
            prev_select_valid <= 1'b1;
        end
    end

    // Exponent modification: offset and direction from the control register
    wire logic [SHIFT_W-1:0] exponent_offset = input_exponent_control[rieps_pkg::EXP_OFFSET_LSB +: SHIFT_W];
    wire logic exponent_invert = input_exponent_control[rieps_pkg::EXP_INVERT_BIT];
    // Three-bit arithmetic wraps, which is exactly the modulo 8
    wire logic [SHIFT_W-1:0] shift_plain = cap_exponent + exponent_offset;
    wire logic [SHIFT_W-1:0] shift_inverted = 3'h7 - cap_exponent + exponent_offset;
    wire logic [SHIFT_W-1:0] shift_amount = exponent_invert ? shift_inverted : shift_plain;
    // Signed shift keeps negative samples negative; the result always fits
    // in the mantissa width, so nothing downstream can wrap
    wire logic signed [MANTISSA_W-1:0] scaled = $signed(cap_mantissa) >>> shift_amount;

    // Mode-dependent acceptance and tagging
    wire logic mode_real = input_mode == rieps_pkg::MODE_SINGLE_REAL;
    wire logic mode_div = input_mode == rieps_pkg::MODE_DIVERSITY_REAL;
    wire logic mode_cplx = input_mode == rieps_pkg::MODE_SINGLE_COMPLEX;
    wire logic select_changed = !prev_select_valid || (cap_select != prev_select);
    wire logic accept = (mode_real && cap_select)
        || (mode_div && select_changed)
        || mode_cplx;
    wire logic tag_channel_a = mode_div ? cap_select : 1'b1;
    wire logic tag_in_phase = mode_cplx ? cap_select : 1'b1;

    // Samples queue here; a stalled consumer fills it and new samples drop
    wire logic fifo_in_ready;
    wire logic fifo_out_valid;
    wire logic [FIFO_W-1:0] fifo_out_data;
    wire logic take_fifo = fifo_out_valid && (!sample_valid_out || sample_ready_in);

    rieps_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_valid_in(accept),
        .in_data_in({tag_channel_a, tag_in_phase, scaled}),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(take_fifo)
    );

    // Output register stage so every stream output is a flip-flop
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sample_valid_out <= 1'b0;
            sample_data_out <= 16'h0000;
            sample_channel_a_out <= 1'b0;
            sample_in_phase_out <= 1'b0;
        end else if (take_fifo) begin
            sample_valid_out <= 1'b1;
            sample_data_out <= fifo_out_data[MANTISSA_W-1:0];
            sample_in_phase_out <= fifo_out_data[MANTISSA_W];
            sample_channel_a_out <= fifo_out_data[MANTISSA_W+1];
        end else if (sample_ready_in) begin
            sample_valid_out <= 1'b0;
        end
    end

    // Status: accepted sample count; the sticky drop flag is kept further below
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sample_count <= 32'h00000000;
        end else if (accept && fifo_in_ready) begin
            sample_count <= sample_count + 32'h00000001;
        end
    end

    // Bus slave: one wait cycle, then the answer with waitrequest low
    rieps_pkg::rieps_bus_state_t bus_state;
    rieps_pkg::rieps_bus_state_t next_bus_state;
    wire logic bus_req = avs_read_in || avs_write_in;
    wire logic [9:0] bus_index = reg_index(avs_address_in);
    wire logic hit_mode = bus_index == rieps_pkg::REG_INPUT_MODE_CONTROL;
    wire logic hit_exp = bus_index == rieps_pkg::REG_INPUT_EXPONENT_CONTROL;
    wire logic hit_status = bus_index == rieps_pkg::REG_INPUT_STATUS;
    wire logic hit_count = bus_index == rieps_pkg::REG_SAMPLE_COUNT;
    wire logic hit_any = hit_mode || hit_exp || hit_status || hit_count;
    wire logic bus_commit = bus_state == rieps_pkg::RIEPS_BUS_DONE;
    wire logic do_write = bus_commit && avs_write_in && avs_byteenable_in[0];
    wire logic clear_overflow = do_write && hit_status && avs_writedata_in[0];
    wire logic [31:0] read_value = hit_mode ? {30'h00000000, input_mode}
        : hit_exp ? {24'h000000, input_exponent_control}
        : hit_status ? {29'h00000000, !fifo_out_valid, !fifo_in_ready, overflow_flag}
        : hit_count ? sample_count
        : 32'h00000000;

    // Next state of the slave
    always_comb begin
        case (bus_state)
            rieps_pkg::RIEPS_BUS_IDLE: begin
                next_bus_state = bus_req ? rieps_pkg::RIEPS_BUS_DONE : rieps_pkg::RIEPS_BUS_IDLE;
            end
            rieps_pkg::RIEPS_BUS_DONE: begin
                next_bus_state = rieps_pkg::RIEPS_BUS_HOLD;
            end
            rieps_pkg::RIEPS_BUS_HOLD: begin
                next_bus_state = rieps_pkg::RIEPS_BUS_IDLE;
            end
            default: begin
                next_bus_state = rieps_pkg::RIEPS_BUS_IDLE;
            end
        endcase
    end

    // Waitrequest must fall in the same cycle the answer is valid,
    // so it is registered from the next state
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bus_state <= rieps_pkg::RIEPS_BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
            avs_response_out <= 2'h0;
        end else begin
            bus_state <= next_bus_state;
            avs_waitrequest_out <= !(next_bus_state == rieps_pkg::RIEPS_BUS_DONE);
            if (next_bus_state == rieps_pkg::RIEPS_BUS_DONE) begin
                avs_readdata_out <= read_value;
                avs_response_out <= hit_any ? 2'h0 : 2'h3;
            end
        end
    end

    // Register writes; only byte lane 0 carries data
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            input_mode <= rieps_pkg::MODE_RESET;
            input_exponent_control <= rieps_pkg::EXP_CTRL_RESET;
        end else if (do_write) begin
            if (hit_mode && avs_writedata_in[1:0] != 2'h3) begin
                input_mode <= avs_writedata_in[rieps_pkg::MODE_LSB +: 2];
            end
            if (hit_exp) begin
                input_exponent_control <= {avs_writedata_in[7:4], 4'h0};
            end
        end
    end

    // Sticky drop flag; a new drop wins over a clear in the same cycle
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            overflow_flag <= 1'b0;
        end else if (accept && !fifo_in_ready) begin
            overflow_flag <= 1'b1;
        end else if (clear_overflow) begin
            overflow_flag <= 1'b0;
        end
    end

    // Checks
    sequence s_select_toggle;
        !$stable(cap_select) ##0 mode_div;
    endsequence

    chk_plain_shift_value: assert property (@(posedge clk_in) disable iff (reset_in)
        !exponent_invert |-> shift_amount == SHIFT_W'(cap_exponent + exponent_offset))
        else $error("Plain shift amount wrong");
    chk_invert_shift_value: assert property (@(posedge clk_in) disable iff (reset_in)
        exponent_invert |-> shift_amount == SHIFT_W'(3'h7 - cap_exponent + exponent_offset))
        else $error("Inverted shift amount wrong");
    chk_sign_kept: assert property (@(posedge clk_in) disable iff (reset_in)
        scaled[MANTISSA_W-1] == cap_mantissa[MANTISSA_W-1])
        else $error("Scaled sample lost its sign");
    chk_capture_edge: assert property (@(posedge clk_in) disable iff (reset_in)
        ##1 cap_mantissa == $past(mantissa_in) && cap_exponent == $past(exponent_in))
        else $error("Pins not captured on the edge");
    chk_real_enable: assert property (@(posedge clk_in) disable iff (reset_in)
        mode_real && !cap_select |-> !accept)
        else $error("Sample taken with enable low");
    chk_div_repeat_drop: assert property (@(posedge clk_in) disable iff (reset_in)
        s_select_toggle ##1 ($stable(cap_select) && mode_div && prev_select_valid) |-> !accept)
        else $error("Repeat sample taken in diversity mode");
    chk_div_channel_tag: assert property (@(posedge clk_in) disable iff (reset_in)
        mode_div |-> tag_channel_a == cap_select)
        else $error("Diversity channel tag wrong");
    chk_cplx_iq_tag: assert property (@(posedge clk_in) disable iff (reset_in)
        mode_cplx |-> accept && tag_in_phase == cap_select)
        else $error("Complex I/Q tag wrong");
    chk_exp_field_write: assert property (@(posedge clk_in) disable iff (reset_in)
        do_write && hit_exp |=> input_exponent_control[7:4] == $past(avs_writedata_in[7:4]))
        else $error("Exponent control write lost");
    chk_mode_write: assert property (@(posedge clk_in) disable iff (reset_in)
        input_mode != 2'h3)
        else $error("Input mode holds an unused code");
    chk_bus_answer: assert property (@(posedge clk_in) disable iff (reset_in)
        bus_req && bus_state == rieps_pkg::RIEPS_BUS_IDLE |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("Bus answer not one cycle after request");
endmodule

// [rieps_adc_model.sv]
`timescale 1ns/100ps
module rieps_adc_model #(
    parameter int ADC_BITS = 12
) (
    // Clock
    input wire logic clk_in,
    // Converter pins
    output logic [15:0] mantissa_out,
    output logic [2:0] exponent_out,
    output logic select_out
);
    // Quiet pins at start; exponent held low as a fixed-point part leaves it
    initial begin
        mantissa_out = 16'h0000;
        exponent_out = 3'h0;
        select_out = 1'b0;
    end
    // One conversion per call, launched just after an edge; narrow codes sit in the top bits
    task automatic drive(input logic [ADC_BITS-1:0] code, input logic [2:0] e, input logic sel);
        @(posedge clk_in);
        mantissa_out <= {code, {(16-ADC_BITS){1'b0}}};
        exponent_out <= e;
        select_out <= sel;
    endtask
endmodule

// [tb.sv]
`timescale 1ns/100ps
module tb;
    localparam logic [11:0] A_MODE = 12'hC00;
    localparam logic [11:0] A_CTRL = 12'hC14;
    localparam logic [11:0] A_STAT = 12'hC18;
    localparam logic [11:0] A_COUNT = 12'hC1C;
    logic clk_in, reset_in, avs_read, avs_write, sample_ready, avs_waitrequest_out, sample_valid_out;
    logic sample_channel_a_out, sample_in_phase_out, channel_select;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata_out, q;
    logic [1:0] avs_response_out, r;
    logic [15:0] sample_data_out, mantissa;
    logic [2:0] exponent;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    // Converter model drives the sample pins
    rieps_adc_model u_rieps_adc_model (.clk_in(clk_in), .mantissa_out(mantissa), .exponent_out(exponent),
        .select_out(channel_select));
    rieps_input_port u_rieps_input_port (.clk_in(clk_in), .reset_in(reset_in), .mantissa_in(mantissa),
        .exponent_in(exponent), .channel_select_in(channel_select), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .avs_response_out(avs_response_out), .sample_valid_out(sample_valid_out), .sample_data_out(sample_data_out),
        .sample_channel_a_out(sample_channel_a_out), .sample_in_phase_out(sample_in_phase_out),
        .sample_ready_in(sample_ready));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic end_of_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // A hang anywhere ends the run as a failure
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    // Avalon request held until waitrequest is sampled low; data taken at that edge only
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        check(n < 50, 1);
        q = avs_readdata_out;
        r = avs_response_out;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Consumer stalls until a sample shows, judges it, then pops it
    task automatic take(input logic [15:0] d, input logic a, input logic i);
        int n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (sample_valid_out !== 1'b1 && n < 50);
        check(sample_valid_out, 1);
        check(sample_data_out, d);
        check(sample_channel_a_out, a);
        check(sample_in_phase_out, i);
        @(posedge clk_in);
        sample_ready <= 1'b1;
        @(posedge clk_in);
        sample_ready <= 1'b0;
    endtask
    task automatic test_registers();
        bus(0, A_MODE, 0);
        check(q[7:0], 8'h00);
        check(r, 2'h0);
        bus(0, A_CTRL, 0);
        check(q[7:0], 8'h00);
        bus(1, A_CTRL, 32'h000000FF);
        bus(0, A_CTRL, 0);
        check(q[7:0], 8'hF0);
        bus(1, A_MODE, 32'h00000001);
        bus(1, A_MODE, 32'h00000003);
        bus(0, A_MODE, 0);
        check(q[1:0], 2'h1);
        bus(0, 12'h010, 0);
        check(r, 2'h3); // Unmapped place answers with an error
        check(q, 32'h00000000);
        bus(1, A_MODE, 0);
    endtask
    // Every exponent with both invert settings and two offsets, signs alternating
    task automatic test_scaling();
        logic signed [15:0] m;
        logic [11:0] code;
        logic [2:0] sh;
        for (int inv = 0; inv < 2; inv++) begin
            for (int k = 0; k < 2; k++) begin
                bus(1, A_CTRL, {24'h0, 3'(k * 6), 1'(inv), 4'h0});
                for (int e = 0; e < 8; e++) begin
                    code = e[0] ? 12'h9A5 : 12'h5A3;
                    m = {code, 4'h0};
                    sh = (inv == 1) ? 3'(7 - e + k * 6) : 3'(e + k * 6);
                    u_rieps_adc_model.drive(code, 3'(e), 1'b1);
                    u_rieps_adc_model.drive(12'h000, 3'h0, 1'b0);
                    take(m >>> sh, 1'b1, 1'b1);
                end
            end
        end
        bus(1, A_CTRL, 0);
    endtask
    // Single real: a low select skips the sample
    task automatic test_enable();
        u_rieps_adc_model.drive(12'h123, 3'h0, 1'b0);
        u_rieps_adc_model.drive(12'h456, 3'h0, 1'b1);
        u_rieps_adc_model.drive(12'h000, 3'h0, 1'b0);
        take(16'h4560, 1'b1, 1'b1);
    endtask
    // Diversity: only the first sample after each select change, tagged by the select level
    task automatic test_diversity();
        bus(1, A_MODE, 32'h00000001);
        u_rieps_adc_model.drive(12'h111, 3'h0, 1'b1);
        u_rieps_adc_model.drive(12'h222, 3'h0, 1'b1);
        u_rieps_adc_model.drive(12'h333, 3'h0, 1'b0);
        u_rieps_adc_model.drive(12'h444, 3'h0, 1'b0);
        u_rieps_adc_model.drive(12'h555, 3'h0, 1'b1);
        u_rieps_adc_model.drive(12'h000, 3'h0, 1'b0);
        take(16'h1110, 1'b1, 1'b1);
        take(16'h3330, 1'b0, 1'b1);
        take(16'h5550, 1'b1, 1'b1);
        take(16'h0000, 1'b0, 1'b1);
        // 32 scaled, 1 enabled and 4 diversity samples accepted so far
        bus(0, A_COUNT, 0);
        check(q, 32'h00000025);
        bus(1, A_MODE, 0);
    endtask
    // Complex mode takes every edge; stalled consumer overfills the buffer
    task automatic test_complex_fifo();
        int n = 0;
        u_rieps_adc_model.drive(12'h7A1, 3'h0, 1'b0);
        bus(1, A_MODE, 32'h00000002);
        repeat (40) @(posedge clk_in);
        bus(0, A_STAT, 0);
        check(q[2:0], 3'h3); // Overflow and full, not empty
        take(16'h7A10, 1'b1, 1'b0);
        // Drain while the in-phase burst arrives, else a full buffer drops all of it
        @(posedge clk_in);
        sample_ready <= 1'b1;
        u_rieps_adc_model.drive(12'h3C5, 3'h0, 1'b1);
        repeat (30) @(posedge clk_in);
        u_rieps_adc_model.drive(12'h000, 3'h0, 1'b0);
        bus(1, A_MODE, 0);
        do begin
            @(negedge clk_in);
            n++;
        end while (sample_in_phase_out !== 1'b1 && n < 60);
        check(sample_in_phase_out, 1'b1);
        check(sample_data_out, 16'h3C50);
        repeat (60) @(posedge clk_in);
        bus(0, A_STAT, 0);
        check(q[2:0], 3'h5); // Drained, overflow still sticky
        bus(1, A_STAT, 32'h00000001);
        bus(0, A_STAT, 0);
        check(q[0], 1'b0); // Sticky flag cleared by writing one
        sample_ready <= 1'b0;
    endtask
    initial begin
        reset_in = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 12'h000;
        avs_writedata = 32'h0;
        sample_ready = 1'b0;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        test_registers();
        test_scaling();
        test_enable();
        test_diversity();
        test_complex_fifo();
        end_of_test();
    end
endmodule
